// File: rtl/master_pic.sv
// Master interrupt controller: init sequence, masking, nesting, vectoring
`timescale 1ns/1ns
`include "pic_consts.svh"

// What this block does, and what board setup and software must do
// (RULE1) Even-port byte write with data bit four set starts initialization.
// (RULE2) Initialization rearms edge sensing; level inputs request while high.
// (RULE3) The first init word clears the whole mask register.
// (RULE4) Initialization selects pending requests for even-port status reads.
// (RULE5) Initialization makes the next acknowledge the first of a pair.
// (RULE6) Local indicator stays high on acknowledge until word six arrives.
// (RULE7) Odd writes follow: words two, three, four, five if asked, six.
// (RULE8) No requests are taken before the last init word is written.
// (RULE9) Second acknowledge drives vector: base bits 7-3, level bits 2-0.
// (RULE10) Levels marked as vectoring slaves get no vector from this block.
// (RULE11) A slave request on an input is passed on as the CPU interrupt.
// (RULE12) Software sends end-of-service to both slave and master.
// (RULE13) Even port: status, first word, eoi, third; odd: mask, words.
// (RULE14) Operation words are accepted any time after initialization.
// (RULE15) Board setup writes the first word to select level and cascade.
// (RULE16) Board setup writes the vector word so level zero maps to base.
// (RULE17) Word three marks which levels carry a vectoring slave.
// (RULE18) Board setup selects normal nested, buffered master, 16-bit mode.
// (RULE19) Board setup writes word six as all ones, every level local.
// (RULE20) After setup, software masks all levels with operation word one.
// (RULE21) Software masks or grounds unused request inputs.
// (RULE22) Software masks the level of any slave not fitted.
// (RULE23) Eoi word: code 011 in top bits, low three bits pick level.
// (RULE24) Level zero highest; in-service blocks same and lower levels.
// (RULE25) Acknowledge drives local indicator low where word six bit is one.
// (RULE26) A set mask bit inhibits only its own level.
module master_pic #(
    parameter int LEVELS = 8
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic io_byte,
    input wire pic_pkg::byte_type io_wdata,
    input wire logic acknowledge_cycle,
    input wire logic [LEVELS-1:0] request_input,
    output pic_pkg::byte_type rd_data_reg,
    output logic int_out_reg,
    output pic_pkg::byte_type vector_reg,
    output logic vector_oe_reg,
    output logic local_ack_indicator_n_reg
);
    import pic_pkg::*;

    // Registers are byte wide, so only eight levels can be served
    if (LEVELS != 8) begin : g_check
        $error("master_pic: LEVELS must be 8");
    end

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    init_state_type init_state_reg, init_state_next;
    status_sel_type status_sel_reg, status_sel_next;
    logic [7:0] level_mask_reg, level_mask_next;
    logic [7:0] in_service_reg, in_service_next;
    logic [7:0] init_word_slave_map_reg, init_word_slave_map_next;
    logic [7:0] init_word_trigger_sel_reg, init_word_trigger_sel_next;
    logic [7:0] init_word_local_sel_reg, init_word_local_sel_next;
    logic [4:0] vector_base_reg, vector_base_next;
    logic word_five_req_reg, word_five_req_next;
    logic local_done_reg, local_done_next;
    logic ack_second_reg, ack_second_next;
    logic ack_prev_reg, ack_prev_next;
    logic [2:0] service_level_reg, service_level_next;
    logic int_out_next;
    byte_type rd_data_next, vector_next;
    logic vector_oe_next, local_n_next;

    logic [7:0] pending_request_reg;
    logic [7:0] allow, eligible, clear_req;
    logic rearm, even_wr, odd_wr, first_wr, ack_rise, ready, any_eligible;
    logic [2:0] top_level;

    // ------------------------------------------------------------------
    // Request sensing
    // ------------------------------------------------------------------
    request_sense #(.LEVELS(LEVELS)) u_sense (
        .clk(clk),
        .reset(reset),
        .request_input(request_input),
        .level_mode(init_word_trigger_sel_reg),
        .rearm(rearm),
        .clear_req(clear_req),
        .pending(pending_request_reg)
    );

    // ------------------------------------------------------------------
    // Priority resolution
    // ------------------------------------------------------------------
    // A level is allowed only if no equal or higher level is in service
    for (genvar i = 0; i < 8; i++) begin : g_prio
        assign allow[i] = ~|in_service_reg[i:0]; // [RULE24]
    end
    assign ready = (init_state_reg == READY);
    assign eligible = pending_request_reg & ~level_mask_reg & allow
        & {8{ready}}; // [RULE8] [RULE26]
    assign any_eligible = |eligible;

    // Lowest set index is the highest priority
    always_comb begin
        top_level = `SPURIOUS_LEVEL;
        for (int j = 7; j >= 0; j--) begin
            if (eligible[j]) begin
                top_level = 3'(j);
            end
        end
    end

    // Byte accesses only; word accesses are ignored
    assign even_wr = io_wr && io_byte && (io_addr == `PORT_EVEN); // [RULE13]
    assign odd_wr = io_wr && io_byte && (io_addr == `PORT_ODD);
    assign first_wr = even_wr && io_wdata[`FIRST_WORD_BIT]; // [RULE1]
    assign ack_rise = acknowledge_cycle && !ack_prev_reg;

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        init_state_next = init_state_reg;
        status_sel_next = status_sel_reg;
        level_mask_next = level_mask_reg;
        in_service_next = in_service_reg;
        init_word_slave_map_next = init_word_slave_map_reg;
        init_word_trigger_sel_next = init_word_trigger_sel_reg;
        init_word_local_sel_next = init_word_local_sel_reg;
        vector_base_next = vector_base_reg;
        word_five_req_next = word_five_req_reg;
        local_done_next = local_done_reg;
        ack_second_next = ack_second_reg;
        ack_prev_next = acknowledge_cycle;
        service_level_next = service_level_reg;
        vector_next = vector_reg;
        vector_oe_next = vector_oe_reg;
        local_n_next = local_ack_indicator_n_reg;
        rd_data_next = `BYTE_ZERO;
        clear_req = `BYTE_ZERO;
        rearm = 1'b0;
        // Operation words on the even port after initialization
        if (even_wr && !first_wr && ready) begin // [RULE14]
            if (io_wdata[`CMD_SEL_HI:`CMD_SEL_LO] == `CMD_SEL_EOI &&
                io_wdata[`EOI_CODE_HI:`EOI_CODE_LO] == `EOI_CODE) begin
                in_service_next[io_wdata[2:0]] = 1'b0; // [RULE23]
            end else if (io_wdata[`CMD_SEL_HI:`CMD_SEL_LO] ==
                         `CMD_SEL_THIRD && io_wdata[`READ_REG_BIT]) begin
                status_sel_next = io_wdata[`READ_SERVICE_BIT] ?
                    SEL_SERVICE : SEL_PENDING;
            end
        end
        // Odd port walks the init sequence, then takes the mask
        if (odd_wr) begin
            case (init_state_reg) // [RULE7]
                WAIT_VECTOR: begin
                    vector_base_next = io_wdata[`VECTOR_HI:`VECTOR_LO];
                    init_state_next = WAIT_SLAVE_MAP;
                end
                WAIT_SLAVE_MAP: begin
                    init_word_slave_map_next = io_wdata; // [RULE17]
                    init_state_next = WAIT_MODE;
                end
                WAIT_MODE: begin
                    // Only normal nesting is built; mode bits are not kept
                    init_state_next = word_five_req_reg ? WAIT_TRIGGER :
                        WAIT_LOCAL;
                end
                WAIT_TRIGGER: begin
                    init_word_trigger_sel_next = io_wdata;
                    init_state_next = WAIT_LOCAL;
                end
                WAIT_LOCAL: begin
                    init_word_local_sel_next = io_wdata;
                    local_done_next = 1'b1;
                    init_state_next = READY;
                end
                READY: begin
                    level_mask_next = io_wdata; // [RULE26] [RULE14]
                end
                default: begin
                    init_state_next = init_state_reg;
                end
            endcase
        end
        // Status reads answer one cycle later
        if (io_rd && io_byte && io_addr == `PORT_EVEN) begin
            rd_data_next = (status_sel_reg == SEL_SERVICE) ?
                in_service_reg : pending_request_reg; // [RULE4]
        end else if (io_rd && io_byte && io_addr == `PORT_ODD) begin
            rd_data_next = level_mask_reg;
        end
        // Acknowledge pair; the set here follows the eoi clear, so it wins
        if (ack_rise && ready) begin
            if (!ack_second_reg) begin
                service_level_next = top_level;
                if (any_eligible) begin
                    in_service_next[top_level] = 1'b1;
                    clear_req[top_level] = 1'b1;
                end
                ack_second_next = 1'b1;
                local_n_next = !(local_done_reg &&
                    init_word_local_sel_reg[top_level]); // [RULE25]
            end else begin
                ack_second_next = 1'b0;
                if (!init_word_slave_map_reg[service_level_reg]) begin
                    vector_next = {vector_base_reg,
                        service_level_reg}; // [RULE9]
                    vector_oe_next = 1'b1;
                end // Slave level: the slave supplies it [RULE10]
                local_n_next = !(local_done_reg &&
                    init_word_local_sel_reg[service_level_reg]); // [RULE6]
            end
        end
        if (!acknowledge_cycle) begin
            vector_oe_next = 1'b0;
            local_n_next = 1'b1;
        end
        // Slave and local requests alike raise the CPU interrupt
        int_out_next = any_eligible && !ack_second_next; // [RULE11]
        // First word overrides all but read data, vector outputs and service level in its cycle
        if (first_wr) begin
            init_state_next = WAIT_VECTOR;
            word_five_req_next = io_wdata[`WORD_FIVE_BIT];
            level_mask_next = `BYTE_ZERO; // [RULE3]
            status_sel_next = SEL_PENDING; // [RULE4]
            ack_second_next = 1'b0; // [RULE5]
            local_done_next = 1'b0; // [RULE6]
            local_n_next = 1'b1; // [RULE6]
            init_word_trigger_sel_next = `BYTE_ZERO;
            in_service_next = `BYTE_ZERO;
            rearm = 1'b1; // [RULE2]
            int_out_next = 1'b0; // [RULE8]
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            init_state_reg <= UNINIT;
            status_sel_reg <= SEL_PENDING;
            level_mask_reg <= `MASK_RESET;
            in_service_reg <= `BYTE_ZERO;
            init_word_slave_map_reg <= `BYTE_ZERO;
            init_word_trigger_sel_reg <= `BYTE_ZERO;
            init_word_local_sel_reg <= `BYTE_ZERO;
            vector_base_reg <= `VECTOR_BASE_RESET;
            word_five_req_reg <= 1'b0;
            local_done_reg <= 1'b0;
            ack_second_reg <= 1'b0;
            ack_prev_reg <= 1'b0;
            service_level_reg <= `SPURIOUS_LEVEL;
            int_out_reg <= 1'b0;
            rd_data_reg <= `BYTE_ZERO;
            vector_reg <= `BYTE_ZERO;
            vector_oe_reg <= 1'b0;
            local_ack_indicator_n_reg <= 1'b1;
        end else begin
            init_state_reg <= init_state_next;
            status_sel_reg <= status_sel_next;
            level_mask_reg <= level_mask_next;
            in_service_reg <= in_service_next;
            init_word_slave_map_reg <= init_word_slave_map_next;
            init_word_trigger_sel_reg <= init_word_trigger_sel_next;
            init_word_local_sel_reg <= init_word_local_sel_next;
            vector_base_reg <= vector_base_next;
            word_five_req_reg <= word_five_req_next;
            local_done_reg <= local_done_next;
            ack_second_reg <= ack_second_next;
            ack_prev_reg <= ack_prev_next;
            service_level_reg <= service_level_next;
            int_out_reg <= int_out_next;
            rd_data_reg <= rd_data_next;
            vector_reg <= vector_next;
            vector_oe_reg <= vector_oe_next;
            local_ack_indicator_n_reg <= local_n_next;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence first_ack_s;
        ack_rise && ready && !ack_second_reg && !first_wr;
    endsequence
    sequence second_ack_s;
        ack_rise && ready && ack_second_reg && !first_wr;
    endsequence

    a_first_word_start: assert property ( // [RULE1]
        first_wr |=> init_state_reg == WAIT_VECTOR && !ack_second_reg)
        else $error("first word did not start init");
    a_mask_cleared: assert property ( // [RULE3]
        first_wr |=> level_mask_reg == 8'h00 && !int_out_reg)
        else $error("mask not cleared by first word");
    a_status_pending: assert property ( // [RULE4]
        first_wr |=> status_sel_reg == SEL_PENDING)
        else $error("status source not pending after init");
    a_ack_pair_reset: assert property ( // [RULE5]
        !ready |-> !ack_second_reg)
        else $error("ack pairing not reset by init");
    a_local_held_high: assert property ( // [RULE6]
        !local_done_reg |=> local_ack_indicator_n_reg)
        else $error("local indicator low before word six");
    a_no_int_early: assert property ( // [RULE8]
        !ready |=> !int_out_reg)
        else $error("interrupt before init complete");
    a_vector_value: assert property ( // [RULE9]
        second_ack_s ##0 (!init_word_slave_map_reg[service_level_reg]
        && acknowledge_cycle) |=> vector_oe_reg &&
        vector_reg == {$past(vector_base_reg), $past(service_level_reg)})
        else $error("wrong vector on second acknowledge");
    a_slave_silent: assert property ( // [RULE10]
        second_ack_s ##0 init_word_slave_map_reg[service_level_reg]
        |=> !vector_oe_reg)
        else $error("vector driven for slave level");
    a_int_forward: assert property ( // [RULE11]
        ready && any_eligible && !ack_second_reg && !ack_rise && !first_wr
        |=> int_out_reg)
        else $error("request not passed to cpu");
    a_eoi_clear: assert property ( // [RULE23]
        even_wr && ready && !first_wr && !ack_rise &&
        io_wdata[7:3] == 5'h0c |=> !in_service_reg[$past(io_wdata[2:0])])
        else $error("specific eoi did not clear level");
    a_nested_block: assert property ( // [RULE24]
        first_ack_s ##0 any_eligible |=>
        $past(top_level) == 3'h0 || !$past(in_service_reg[0]))
        else $error("lower level taken over in-service");
    a_local_level: assert property ( // [RULE25]
        first_ack_s ##0 (local_done_reg && acknowledge_cycle) |=>
        local_ack_indicator_n_reg ==
        !$past(init_word_local_sel_reg[top_level]))
        else $error("local indicator wrong for level");
    a_mask_write: assert property ( // [RULE26]
        odd_wr && ready && !first_wr |=> level_mask_reg == $past(io_wdata))
        else $error("mask write not stored");
endmodule : master_pic

// File: rtl/pic_consts.svh
// Constants of the master interrupt controller: ports, fields, reset values
`ifndef PIC_CONSTS_SVH
`define PIC_CONSTS_SVH

// ----------------------------------------------------------------------
// Port addresses
// ----------------------------------------------------------------------
`define PORT_EVEN 8'he0
`define PORT_ODD 8'he2

// ----------------------------------------------------------------------
// Field positions and codes
// ----------------------------------------------------------------------
`define FIRST_WORD_BIT 4
`define WORD_FIVE_BIT 3
`define CMD_SEL_HI 4
`define CMD_SEL_LO 3
`define CMD_SEL_EOI 2'h0
`define CMD_SEL_THIRD 2'h1
`define EOI_CODE_HI 7
`define EOI_CODE_LO 5
`define EOI_CODE 3'h3
`define READ_REG_BIT 1
`define READ_SERVICE_BIT 0
`define VECTOR_HI 7
`define VECTOR_LO 3
`define SPURIOUS_LEVEL 3'h7

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define MASK_RESET 8'hff
`define BYTE_ZERO 8'h00
`define VECTOR_BASE_RESET 5'h00

`endif

// File: rtl/pic_pkg.sv
// Types shared by the master interrupt controller files
package pic_pkg;
    typedef logic [7:0] byte_type;
    typedef enum logic [2:0] {
        UNINIT, WAIT_VECTOR, WAIT_SLAVE_MAP, WAIT_MODE,
        WAIT_TRIGGER, WAIT_LOCAL, READY
    } init_state_type;
    typedef enum logic {SEL_PENDING, SEL_SERVICE} status_sel_type;
endpackage : pic_pkg

// File: rtl/request_sense.sv
// Per-level request synchroniser with edge or level sensing
`timescale 1ns/1ns
module request_sense #(
    parameter int LEVELS = 8
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [LEVELS-1:0] request_input,
    input wire logic [LEVELS-1:0] level_mode,
    input wire logic rearm,
    input wire logic [LEVELS-1:0] clear_req,
    output logic [LEVELS-1:0] pending
);
    // ------------------------------------------------------------------
    // One slice per request level
    // ------------------------------------------------------------------
    for (genvar i = 0; i < LEVELS; i++) begin : g_level
        logic meta_reg, sync_reg, prev_reg, latch_reg;
        logic prev_next, latch_next;
        // Rearm forces prev high, so a line already high needs a new rise
        always_comb begin
            prev_next = rearm ? 1'b1 : sync_reg;
            latch_next = latch_reg;
            if (clear_req[i]) begin
                latch_next = 1'b0;
            end
            // Edge seen wins over a clear in the same cycle
            if (sync_reg && !prev_reg) begin
                latch_next = 1'b1;
            end
            if (rearm) begin
                latch_next = 1'b0;
            end
        end
        // Two-stage synchroniser, meta_reg feeds only sync_reg
        always_ff @(posedge clk or posedge reset) begin
            if (reset) begin
                meta_reg <= 1'b0;
                sync_reg <= 1'b0;
                prev_reg <= 1'b1;
                latch_reg <= 1'b0;
            end else begin
                meta_reg <= request_input[i];
                sync_reg <= meta_reg;
                prev_reg <= prev_next;
                latch_reg <= latch_next;
            end
        end
        assign pending[i] = level_mode[i] ? sync_reg : latch_reg; // [RULE2]
    end
endmodule : request_sense

// File: tb/slave_requesters.sv
// Slave controllers and local sources that drive the request lines
`timescale 1ns/1ns
module slave_requesters (
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] want,
    output logic [7:0] request_input
);
    logic [7:0] line_reg;
    logic [7:0] line_next;
    // ------------------------------------------------------------------
    // Request lines
    // ------------------------------------------------------------------
    // Each line follows its want bit one clock later, whether or not it is served
    always_comb begin
        line_next = want;
    end
    // Lines rest low after reset, so no stray request is seen
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            line_reg <= 8'h00;
        end else begin
            line_reg <= line_next;
        end
    end
    assign request_input = line_reg;
endmodule : slave_requesters

// File: tb/tb_master_pic.sv
// Self-checking bench for the master interrupt controller
`timescale 1ns/1ns
`include "pic_consts.svh"
module tb_master_pic;
    import pic_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] io_addr = 8'h00;
    logic io_wr = 1'b0;
    logic io_rd = 1'b0;
    logic io_byte = 1'b1;
    byte_type io_wdata = 8'h00;
    logic acknowledge_cycle = 1'b0;
    logic [7:0] want = 8'h00;
    logic [7:0] request_input;
    byte_type rd_data_reg;
    byte_type vector_reg;
    logic int_out_reg;
    logic vector_oe_reg;
    logic local_ack_indicator_n_reg;
    int err_count = 0;
    int comparisons = 0;
    int cycles = 0;
    byte_type rd;
    byte_type vec;
    logic ind_n;
    logic oe;

    master_pic #(.LEVELS(8)) i_master_pic (.clk(clk), .reset(reset),
        .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_byte(io_byte),
        .io_wdata(io_wdata), .acknowledge_cycle(acknowledge_cycle),
        .request_input(request_input), .rd_data_reg(rd_data_reg),
        .int_out_reg(int_out_reg), .vector_reg(vector_reg),
        .vector_oe_reg(vector_oe_reg),
        .local_ack_indicator_n_reg(local_ack_indicator_n_reg));
    slave_requesters i_slave_requesters (.clk(clk), .reset(reset),
        .want(want), .request_input(request_input));

    always #10 clk = ~clk;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic conclude;
        if (err_count == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : conclude

    task automatic check_byte(input string n, input byte_type e,
                              input byte_type g);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : check_byte

    task automatic check_bit(input string n, input logic e, input logic g);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("wrong value %s expected %b seen %b", n, e, g);
        end
    endtask : check_bit

    task automatic wr(input logic [7:0] a, input byte_type d);
        @(posedge clk);
        io_addr <= a;
        io_wdata <= d;
        io_wr <= 1'b1;
        @(posedge clk);
        io_wr <= 1'b0;
    endtask : wr

    task automatic rd_port(input logic [7:0] a, output byte_type d);
        @(posedge clk);
        io_addr <= a;
        io_rd <= 1'b1;
        @(posedge clk);
        io_rd <= 1'b0;
        // Read data stands one cycle; take it mid-cycle, return on an edge
        @(negedge clk);
        d = rd_data_reg;
        @(posedge clk);
    endtask : rd_port

    // One acknowledge cycle; outputs are captured while it is held
    task automatic ack(output logic n, output logic o, output byte_type v);
        @(posedge clk);
        acknowledge_cycle <= 1'b1;
        repeat (2) @(posedge clk);
        #1 n = local_ack_indicator_n_reg;
        o = vector_oe_reg;
        v = vector_reg;
        @(posedge clk);
        acknowledge_cycle <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : ack

    // Cut a hang short well beyond the expected run length
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_count++;
            conclude();
        end
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        wr(`PORT_EVEN, 8'h39);
        rd_port(`PORT_ODD, rd);
        check_byte("mask after init", 8'h00, rd);
        wr(`PORT_ODD, 8'h20);
        wr(`PORT_ODD, 8'h50);
        wr(`PORT_ODD, 8'h0d);
        wr(`PORT_ODD, 8'hff);
        want <= 8'h20;
        repeat (6) @(posedge clk);
        check_bit("int before ready", 1'b0, int_out_reg);
        ack(ind_n, oe, vec);
        check_bit("local before word six", 1'b1, ind_n);
        wr(`PORT_ODD, 8'hff);
        repeat (6) @(posedge clk);
        check_bit("int when ready", 1'b1, int_out_reg);
        wr(`PORT_ODD, 8'hff);
        repeat (4) @(posedge clk);
        check_bit("int all masked", 1'b0, int_out_reg);
        io_byte <= 1'b0;
        wr(`PORT_ODD, 8'h00);
        io_byte <= 1'b1;
        rd_port(`PORT_ODD, rd);
        check_byte("mask after word write", 8'hff, rd);
        rd_port(8'he4, rd);
        check_byte("unmapped read", 8'h00, rd);
        wr(`PORT_ODD, 8'hdf);
        repeat (4) @(posedge clk);
        check_bit("int level five", 1'b1, int_out_reg);
        ack(ind_n, oe, vec);
        check_bit("local on ack", 1'b0, ind_n);
        check_bit("int after first ack", 1'b0, int_out_reg);
        ack(ind_n, oe, vec);
        check_byte("vector level five", 8'h25, vec);
        check_bit("vector driven", 1'b1, oe);
        // Enable levels three to six; level four carries a vectoring slave
        wr(`PORT_ODD, 8'h87);
        want <= 8'h60;
        repeat (6) @(posedge clk);
        check_bit("lower level blocked", 1'b0, int_out_reg);
        want <= 8'h70;
        repeat (6) @(posedge clk);
        check_bit("higher level passes", 1'b1, int_out_reg);
        ack(ind_n, oe, vec);
        ack(ind_n, oe, vec);
        check_bit("slave level no vector", 1'b0, oe);
        wr(`PORT_EVEN, 8'h0b);
        rd_port(`PORT_EVEN, rd);
        check_byte("in service pair", 8'h30, rd);
        wr(`PORT_EVEN, 8'h64);
        rd_port(`PORT_EVEN, rd);
        check_byte("in service after eoi", 8'h20, rd);
        // Leave a pair half done so re-init must restart the pairing
        want <= 8'h20;
        ack(ind_n, oe, vec);
        wr(`PORT_EVEN, 8'h31);
        wr(`PORT_ODD, 8'h20);
        wr(`PORT_ODD, 8'h50);
        wr(`PORT_ODD, 8'h0d);
        wr(`PORT_ODD, 8'hff);
        repeat (6) @(posedge clk);
        check_bit("held line no edge", 1'b0, int_out_reg);
        want <= 8'h22;
        repeat (6) @(posedge clk);
        check_bit("edge raises int", 1'b1, int_out_reg);
        rd_port(`PORT_EVEN, rd);
        check_byte("status is pending", 8'h02, rd);
        ack(ind_n, oe, vec);
        ack(ind_n, oe, vec);
        check_byte("vector after re-init", 8'h21, vec);
        check_bit("vector driven again", 1'b1, oe);
        conclude();
    end
endmodule : tb_master_pic
